// [verilog/jds_top.sv]
/*
 * Test-port data registers (boundary, identification, bypass) with the
 * instruction register, plus configuration source select and the target
 * chain port mux, reached from software over classic Wishbone.
 * Assumes the test clock is far slower than clock (edges found by sampling)
 * and that flash and host engines supply their own serial streams.
 */
`timescale 1ns/1ps
module jds_top
  import jds_pkg::*;
(
  // System
  input wire logic clock,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Test scan port pins
  input wire logic test_port_clock,
  input wire logic test_port_mode_select,
  input wire logic test_port_data_in,
  output logic test_port_data_out,
  output logic test_port_data_out_en_n,
  // Configuration pins and status
  input wire logic mode_select_pin,
  input wire logic [2:0] image_address_pin,
  input wire logic [5:0] config_status,
  // Boundary-scanned device pins
  input wire logic [JDS_BSR_LEN-1:0] bscan_pin_in,
  output logic [JDS_BSR_LEN-1:0] bscan_pin_drive,
  output logic bscan_pin_drive_en,
  // Serial streams from the flash and host engines
  input wire jds_chain_t flash_chain,
  input wire jds_chain_t host_chain,
  // Target chain scan port
  output jds_chain_t target_chain_scan_port,
  input wire logic target_chain_return,
  output logic chain_return,
  // Source select results
  output jds_src_t config_source,
  output logic [2:0] image_address_select,
  output logic config_mode_select
);

  jds_state_t r;
  jds_state_t next_r;
  jds_pins_t pins;
  jds_pins_t p;
  logic tck_rise;
  logic tck_fall;
  logic eff_mode;
  logic [2:0] eff_addr;
  logic wb_req;
  logic bsr_sel;
  logic serial_out;
  jds_src_t src_pick;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic jds_tap_t tap_step(input jds_tap_t s, input logic tms);
    case (s)
      JDS_TLR: tap_step = tms ? JDS_TLR : JDS_RTI;
      JDS_RTI: tap_step = tms ? JDS_SELDR : JDS_RTI;
      JDS_SELDR: tap_step = tms ? JDS_SELIR : JDS_CAPDR;
      JDS_CAPDR: tap_step = tms ? JDS_EX1DR : JDS_SHDR;
      JDS_SHDR: tap_step = tms ? JDS_EX1DR : JDS_SHDR;
      JDS_EX1DR: tap_step = tms ? JDS_UPDDR : JDS_PAUSEDR;
      JDS_PAUSEDR: tap_step = tms ? JDS_EX2DR : JDS_PAUSEDR;
      JDS_EX2DR: tap_step = tms ? JDS_UPDDR : JDS_SHDR;
      JDS_UPDDR: tap_step = tms ? JDS_SELDR : JDS_RTI;
      JDS_SELIR: tap_step = tms ? JDS_TLR : JDS_CAPIR;
      JDS_CAPIR: tap_step = tms ? JDS_EX1IR : JDS_SHIR;
      JDS_SHIR: tap_step = tms ? JDS_EX1IR : JDS_SHIR;
      JDS_EX1IR: tap_step = tms ? JDS_UPDIR : JDS_PAUSEIR;
      JDS_PAUSEIR: tap_step = tms ? JDS_EX2IR : JDS_PAUSEIR;
      JDS_EX2IR: tap_step = tms ? JDS_UPDIR : JDS_SHIR;
      JDS_UPDIR: tap_step = tms ? JDS_SELDR : JDS_RTI;
      default: tap_step = JDS_TLR;
    endcase
  endfunction

  // Boundary register is the data path for EXTEST and SAMPLE/PRELOAD
  function automatic logic is_bsr_op(input logic [JDS_IR_W-1:0] ir);
    is_bsr_op = (ir == JDS_OP_EXTEST) || (ir == JDS_OP_SAMPLE);
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    byte_merge = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        byte_merge[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction

  // ***************************************************************
  // Pin synchroniser
  // ***************************************************************
  always_comb begin
    pins.bsr_pins = bscan_pin_in;
    pins.chain_ret = target_chain_return;
    pins.addr_pin = image_address_pin;
    pins.mode_pin = mode_select_pin;
    pins.tdi = test_port_data_in;
    pins.tms = test_port_mode_select;
    pins.tck = test_port_clock;
  end

  jds_pin_sync u_sync (
    .clock(clock),
    .reset(reset),
    .pins(pins),
    .pins_sync(p)
  );

  // ***************************************************************
  // Source selection
  // ***************************************************************
  always_comb begin
    eff_mode = r.ctrl[JDS_CTL_MODE_OVR] ? r.ctrl[JDS_CTL_MODE] : p.mode_pin;
    eff_addr = r.ctrl[JDS_CTL_ADDR_OVR] ? r.ctrl[JDS_CTL_ADDR_LSB +: 3] : p.addr_pin;
    if (r.ctrl[JDS_CTL_PORT_RST]) begin
      src_pick = JDS_SRC_NONE;
    end else if (!eff_mode) begin
      src_pick = JDS_SRC_FLASH;
    end else if (!r.ctrl[JDS_CTL_START]) begin
      src_pick = JDS_SRC_TEST;
    end else if (r.ctrl[JDS_CTL_SEL]) begin
      src_pick = JDS_SRC_HOST;
    end else begin
      src_pick = JDS_SRC_FLASH;
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  assign tck_rise = p.tck & ~r.tck_d;
  assign tck_fall = ~p.tck & r.tck_d;
  assign wb_req = wb_cyc_i & wb_stb_i & ~r.wb_ack;
  assign bsr_sel = is_bsr_op(r.ir);

  always_comb begin
    if (r.tap == JDS_SHIR) begin
      serial_out = r.ir_sh[0];
    end else if (bsr_sel) begin
      serial_out = r.bsr_sh[0];
    end else begin
      serial_out = r.dr_sh[0];
    end
  end

  always_comb begin
    next_r = r;
    next_r.tck_d = p.tck;
    if (tck_rise) begin
      next_r.tap = tap_step(r.tap, p.tms);
      case (r.tap)
        JDS_TLR: begin
          next_r.ir = JDS_OP_IDCODE;
        end
        JDS_CAPDR: begin
          if (bsr_sel) begin
            next_r.bsr_sh = p.bsr_pins;
          end else if (r.ir == JDS_OP_IDCODE) begin
            next_r.dr_sh = JDS_IDCODE;
          end else begin
            next_r.dr_sh = 32'h00000000;
          end
        end
        JDS_SHDR: begin
          if (bsr_sel) begin
            next_r.bsr_sh = {p.tdi, r.bsr_sh[JDS_BSR_LEN-1:1]};
          end else if (r.ir == JDS_OP_IDCODE) begin
            next_r.dr_sh = {p.tdi, r.dr_sh[31:1]};
          end else begin
            next_r.dr_sh[0] = p.tdi;
          end
        end
        JDS_UPDDR: begin
          if (bsr_sel) begin
            next_r.bsr_upd = r.bsr_sh;
          end
        end
        JDS_CAPIR: begin
          next_r.ir_sh = {config_status, JDS_IR_CAPTURE_LOW};
        end
        JDS_SHIR: begin
          next_r.ir_sh = {p.tdi, r.ir_sh[JDS_IR_W-1:1]};
        end
        JDS_UPDIR: begin
          next_r.ir = r.ir_sh;
        end
        default: begin
        end
      endcase
    end
    if (r.tap == JDS_UPDDR && !bsr_sel && r.ir != JDS_OP_IDCODE) begin
      next_r.dr_sh[0] = 1'b0;
    end
    next_r.bsr_oe = (r.ir == JDS_OP_EXTEST);
    if (tck_fall) begin
      next_r.own_out = serial_out;
      if (r.src == JDS_SRC_TEST) begin
        next_r.tdo = p.chain_ret;
      end else begin
        next_r.tdo = serial_out;
      end
      next_r.tdo_en_n = !(r.tap == JDS_SHDR || r.tap == JDS_SHIR);
    end
    next_r.src = src_pick;
    next_r.image_addr = eff_addr;
    next_r.chain_ret = p.chain_ret;
    case (r.src)
      JDS_SRC_FLASH: next_r.chain = flash_chain;
      JDS_SRC_HOST: next_r.chain = host_chain;
      JDS_SRC_TEST: next_r.chain = '{tck: p.tck, tms: p.tms, tdi: r.own_out};
      default: next_r.chain = JDS_CHAIN_IDLE;
    endcase
    next_r.wb_ack = wb_req;
    if (wb_req) begin
      next_r.wb_dat = 32'h00000000;
      if (wb_we_i && wb_adr_i == JDS_ADDR_CTRL) begin
        next_r.ctrl = byte_merge(r.ctrl, wb_dat_i, wb_sel_i) & JDS_CTRL_MASK;
      end else if (!wb_we_i && wb_adr_i == JDS_ADDR_CTRL) begin
        next_r.wb_dat = r.ctrl;
      end else if (!wb_we_i && wb_adr_i == JDS_ADDR_STATUS) begin
        next_r.wb_dat = {14'h0000, r.ir, r.tap, r.src, r.image_addr, eff_mode};
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      r <= '0;
      r.tap <= JDS_TLR;
      r.ir <= JDS_OP_IDCODE;
      r.tdo_en_n <= 1'b1;
      r.ctrl <= JDS_CTRL_RESET;
      r.src <= JDS_SRC_NONE;
      r.chain <= JDS_CHAIN_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign wb_dat_o = r.wb_dat;
  assign wb_ack_o = r.wb_ack;
  assign test_port_data_out = r.tdo;
  assign test_port_data_out_en_n = r.tdo_en_n;
  assign bscan_pin_drive = r.bsr_upd;
  assign bscan_pin_drive_en = r.bsr_oe;
  assign target_chain_scan_port = r.chain;
  assign chain_return = r.chain_ret;
  assign config_source = r.src;
  assign image_address_select = r.image_addr;
  assign config_mode_select = eff_mode;

  // ***************************************************************
  // Checks
  // ***************************************************************
  bypass_clear_a: assert property (
    @(posedge clock) disable iff (reset)
    (r.tap == JDS_UPDDR && r.ir == JDS_OP_BYPASS) |=> (r.dr_sh[0] == 1'b0))
    else $error("bypass bit not cleared in update state");

  idcode_load_a: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && r.tap == JDS_CAPDR && r.ir == JDS_OP_IDCODE)
      |=> (r.dr_sh == JDS_IDCODE && r.dr_sh[0] == 1'b1))
    else $error("identification value not captured");

  bypass_path_a: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && r.tap == JDS_SHDR && r.ir == JDS_OP_BYPASS)
      |=> (r.dr_sh[0] == $past(p.tdi)))
    else $error("bypass flop did not take data in");

  tdo_fall_a: assert property (
    @(posedge clock) disable iff (reset)
    $changed(r.tdo) |-> $past(tck_fall))
    else $error("data out changed off a falling edge");

  port_reset_a: assert property (
    @(posedge clock) disable iff (reset)
    r.ctrl[JDS_CTL_PORT_RST] |=> (r.src == JDS_SRC_NONE) ##1 (r.chain == JDS_CHAIN_IDLE))
    else $error("source active during port reset");

  mode_zero_a: assert property (
    @(posedge clock) disable iff (reset)
    (!r.ctrl[JDS_CTL_PORT_RST] && !eff_mode) |=> (r.src == JDS_SRC_FLASH))
    else $error("mode zero did not pick flash");

  start_flash_a: assert property (
    @(posedge clock) disable iff (reset)
    (!r.ctrl[JDS_CTL_PORT_RST] && eff_mode && r.ctrl[JDS_CTL_START] && !r.ctrl[JDS_CTL_SEL])
      |=> (r.src == JDS_SRC_FLASH))
    else $error("start did not pick flash");

  host_pick_a: assert property (
    @(posedge clock) disable iff (reset)
    (!r.ctrl[JDS_CTL_PORT_RST] && eff_mode && r.ctrl[JDS_CTL_START] && r.ctrl[JDS_CTL_SEL])
      |=> (r.src == JDS_SRC_HOST))
    else $error("host source not picked");

  test_pick_a: assert property (
    @(posedge clock) disable iff (reset)
    (!r.ctrl[JDS_CTL_PORT_RST] && eff_mode && !r.ctrl[JDS_CTL_START])
      |=> (r.src == JDS_SRC_TEST))
    else $error("test port not picked");

  addr_override_a: assert property (
    @(posedge clock) disable iff (reset)
    r.ctrl[JDS_CTL_ADDR_OVR] |=> (r.image_addr == $past(r.ctrl[JDS_CTL_ADDR_LSB +: 3])))
    else $error("image address override ignored");

  ir_update_a: assert property (
    @(posedge clock) disable iff (reset)
    (tck_rise && r.tap == JDS_UPDIR) |=> (r.ir == $past(r.ir_sh)))
    else $error("instruction not updated");

  extest_drive_a: assert property (
    @(posedge clock) disable iff (reset)
    (r.ir == JDS_OP_EXTEST) |=> bscan_pin_drive_en)
    else $error("pins not driven under EXTEST");

endmodule

// [verilog/jds_pkg.sv]
/*
 * Package for the test-port data registers and configuration source select.
 * Assumes one 200 MHz system clock; all outside pins except config_status
 * are synchronised before use.
 */
// Notes on behaviour
// - Boundary register drives/observes pins in EXTEST/SAMPLE
// - Fixed 32-bit identification register
// - IDCODE puts identification register between data pins
// - Id layout: version, family, size, maker, one
// - Bypass routes data through one flip-flop
// - Bypass flop cleared in Update-DR
// - Data out changes on test clock falling edge
// - Chosen source drives serial target-chain traffic
// - Control bits reset zero, mode pin defaults one
// - Address override uses register image address
// - Mode override uses register mode bit
// - Port reset is a partial reset only
// - Mode 0: flash card configures immediately
// - Mode 1, select 0: flash after start
// - Mode 1, select 1: host port source
// - Mode 1, start 0: test port drives chain
// - Flash path runs alongside other interfaces
// - Test port reaches chain only when free
// - Decode 11111111 bypass, 00001001 identification
package jds_pkg;

  // ***************************************************************
  // Sizes and instruction codes
  // ***************************************************************
  localparam int JDS_BSR_LEN = 109;
  localparam int JDS_IR_W = 8;
  localparam logic [7:0] JDS_OP_BYPASS = 8'hFF;
  localparam logic [7:0] JDS_OP_IDCODE = 8'h09;
  localparam logic [7:0] JDS_OP_SAMPLE = 8'h01;
  localparam logic [7:0] JDS_OP_EXTEST = 8'h00;
  localparam logic [1:0] JDS_IR_CAPTURE_LOW = 2'h1;

  // Identification fields, values arbitrary
  localparam logic [3:0] JDS_ID_VERSION = 4'h2;
  localparam logic [7:0] JDS_ID_FAMILY = 8'h3C;
  localparam logic [7:0] JDS_ID_ARRAY = 8'h15;
  localparam logic [10:0] JDS_ID_MAKER = 11'h2A5;
  localparam logic [31:0] JDS_IDCODE = {JDS_ID_VERSION, JDS_ID_FAMILY, JDS_ID_ARRAY,
                                        JDS_ID_MAKER, 1'b1};

  // ***************************************************************
  // Register map and control fields
  // ***************************************************************
  localparam logic [7:0] JDS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] JDS_ADDR_STATUS = 8'h04;
  localparam int JDS_CTL_MODE = 0;
  localparam int JDS_CTL_SEL = 1;
  localparam int JDS_CTL_START = 2;
  localparam int JDS_CTL_ADDR_OVR = 3;
  localparam int JDS_CTL_MODE_OVR = 4;
  localparam int JDS_CTL_PORT_RST = 7;
  localparam int JDS_CTL_ADDR_LSB = 8;
  localparam logic [31:0] JDS_CTRL_MASK = 32'h0000079F;
  localparam logic [31:0] JDS_CTRL_RESET = 32'h00000000;
  localparam logic JDS_MODE_PIN_RESET = 1'b1;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    JDS_SRC_NONE = 2'h0,
    JDS_SRC_FLASH = 2'h1,
    JDS_SRC_TEST = 2'h2,
    JDS_SRC_HOST = 2'h3
  } jds_src_t;

  typedef enum logic [3:0] {
    JDS_TLR = 4'h0, JDS_RTI = 4'h1, JDS_SELDR = 4'h3, JDS_CAPDR = 4'h2,
    JDS_SHDR = 4'h6, JDS_EX1DR = 4'h7, JDS_PAUSEDR = 4'h5, JDS_EX2DR = 4'h4,
    JDS_UPDDR = 4'hC, JDS_SELIR = 4'hD, JDS_CAPIR = 4'hF, JDS_SHIR = 4'hE,
    JDS_EX1IR = 4'hA, JDS_PAUSEIR = 4'hB, JDS_EX2IR = 4'h9, JDS_UPDIR = 4'h8
  } jds_tap_t;

  typedef struct packed {
    logic [JDS_BSR_LEN-1:0] bsr_pins;
    logic chain_ret;
    logic [2:0] addr_pin;
    logic mode_pin;
    logic tdi;
    logic tms;
    logic tck;
  } jds_pins_t;

  typedef struct packed {
    jds_pins_t s2;
    jds_pins_t s1;
  } jds_sync_t;

  localparam jds_pins_t JDS_PINS_RESET = '{mode_pin: JDS_MODE_PIN_RESET, default: '0};
  localparam jds_sync_t JDS_SYNC_RESET = '{s2: JDS_PINS_RESET, s1: JDS_PINS_RESET};

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jds_chain_t;

  localparam jds_chain_t JDS_CHAIN_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0};

  typedef struct packed {
    jds_tap_t tap;
    logic [JDS_IR_W-1:0] ir;
    logic [JDS_IR_W-1:0] ir_sh;
    logic [31:0] dr_sh;
    logic [JDS_BSR_LEN-1:0] bsr_sh;
    logic [JDS_BSR_LEN-1:0] bsr_upd;
    logic bsr_oe;
    logic tck_d;
    logic own_out;
    logic tdo;
    logic tdo_en_n;
    logic [31:0] ctrl;
    jds_src_t src;
    logic [2:0] image_addr;
    jds_chain_t chain;
    logic chain_ret;
    logic wb_ack;
    logic [31:0] wb_dat;
  } jds_state_t;

endpackage

// [verilog/jds_pin_sync.sv]
/*
 * Two-flop synchroniser for every pin that enters from outside, except config_status.
 * Assumes the pins are asynchronous to clock; reset is synchronous.
 */
`timescale 1ns/1ps
module jds_pin_sync
  import jds_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Pins in and synchronised copy out
  input wire jds_pins_t pins,
  output jds_pins_t pins_sync
);

  jds_sync_t r;
  jds_sync_t next_r;

  // ***************************************************************
  // Two stages; the first is read only by the second
  // ***************************************************************
  always_comb begin
    next_r = r;
    next_r.s1 = pins;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      r <= JDS_SYNC_RESET;
    end else begin
      r <= next_r;
    end
  end

  assign pins_sync = r.s2;

endmodule

// [tb/jds_chain_model.sv]
/*
 * Model of a target chain of one device held in bypass.
 * Assumes the chain port idles with its clock low and is driven by jds_top.
 */
`timescale 1ns/1ps
module jds_chain_model
  import jds_pkg::*;
(
  // Reset
  input wire logic reset,
  // Chain port from the block
  input wire jds_chain_t chain,
  output logic chain_ret
);
  logic held;

  // ***************************************************************
  // One bypass stage: capture on rise, present on fall
  // ***************************************************************
  always @(posedge chain.tck or posedge reset) begin
    if (reset) begin
      held <= 1'b0;
    end else begin
      held <= chain.tdi;
    end
  end

  always @(negedge chain.tck or posedge reset) begin
    if (reset) begin
      chain_ret <= 1'b0;
    end else begin
      chain_ret <= held;
    end
  end
endmodule

// [tb/jds_top_tb.sv]
/*
 * Self-checking bench for jds_top: Wishbone control, source select,
 * chain mux and the test scan port data registers.
 * Assumes the tester is this bench and the chain is jds_chain_model.
 */
`timescale 1ns/1ps
module jds_top_tb;
  import jds_pkg::*;
  logic clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, lfsr, rd, ctrl;
  logic tck, tms, tdi, tdo, tdo_en_n, mode_pin, drive_en, tgt_ret, chain_ret, eff_mode;
  logic [2:0] addr_pin, img;
  logic [5:0] status;
  logic [JDS_BSR_LEN-1:0] pin_in, pin_drive, sout;
  jds_chain_t flash_c, host_c, tgt;
  jds_src_t src, es;
  int err_total, comparisons;
  logic [31:0] corners [6] = '{32'h0, 32'h11, 32'h15, 32'h17, 32'h80, 32'h50E};
  logic [7:0] codes [2] = '{JDS_OP_BYPASS, 8'h5A};

  jds_top i_jds_top (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .test_port_clock(tck),
    .test_port_mode_select(tms), .test_port_data_in(tdi), .test_port_data_out(tdo),
    .test_port_data_out_en_n(tdo_en_n), .mode_select_pin(mode_pin),
    .image_address_pin(addr_pin), .config_status(status), .bscan_pin_in(pin_in),
    .bscan_pin_drive(pin_drive), .bscan_pin_drive_en(drive_en), .flash_chain(flash_c),
    .host_chain(host_c), .target_chain_scan_port(tgt), .target_chain_return(tgt_ret),
    .chain_return(chain_ret), .config_source(src), .image_address_select(img),
    .config_mode_select(eff_mode));

  jds_chain_model i_jds_chain_model (.reset(reset), .chain(tgt), .chain_ret(tgt_ret));

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic [31:0] next_rand(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic jds_src_t src_of(input logic [31:0] c, input logic pin);
    logic m;
    m = c[JDS_CTL_MODE_OVR] ? c[JDS_CTL_MODE] : pin;
    if (c[JDS_CTL_PORT_RST]) return JDS_SRC_NONE;
    if (!m) return JDS_SRC_FLASH;
    if (!c[JDS_CTL_START]) return JDS_SRC_TEST;
    return c[JDS_CTL_SEL] ? JDS_SRC_HOST : JDS_SRC_FLASH;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    check("wb_ack", n, 32'h2);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clock);
  endtask

  // One 48 ns test clock period; edges on whole ns, clear of rising clock edges
  task automatic tbit(input logic m, input logic d, output logic q);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    #24;
    q = tdo;
    tck <= 1'b1;
    #24;
  endtask

  task automatic scan(input logic ir, input int n, input logic [JDS_BSR_LEN-1:0] din,
                      output logic [JDS_BSR_LEN-1:0] dout);
    logic b;
    dout = '0;
    @(negedge clock);
    tbit(1'b1, 1'b0, b);
    if (ir) tbit(1'b1, 1'b0, b);
    tbit(1'b0, 1'b0, b);
    tbit(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++) begin
      tbit(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tbit(1'b1, 1'b0, b);
    tbit(1'b0, 1'b0, b);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ***************************************************************
  // Clock, watchdog and main sequence
  // ***************************************************************
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #300000;
    err_total++;
    conclude();
  end

  initial begin
    logic b;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {tck, tms, tdi, mode_pin, addr_pin, flash_c, host_c} = '0;
    err_total = 0;
    comparisons = 0;
    lfsr = 32'hbcff9096;
    status = 6'h2D;
    pin_in = JDS_BSR_LEN'({4{lfsr}});
    reset = 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("mode_default", eff_mode, 1'b1);
    @(posedge clock);
    repeat (4) @(posedge clock);
    wb(1'b0, JDS_ADDR_CTRL, 32'h0, rd);
    check("ctrl_reset", rd, JDS_CTRL_RESET);
    wb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h40, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    // Port reset held while the tester works the data registers
    mode_pin <= 1'b1;
    wb(1'b1, JDS_ADDR_CTRL, 32'h80, rd);
    repeat (6) @(posedge clock);
    check("src_none", src, JDS_SRC_NONE);
    check("chain_idle", tgt, JDS_CHAIN_IDLE);
    @(negedge clock);
    for (int i = 0; i < 6; i++) tbit(1'b1, 1'b0, b);
    tbit(1'b0, 1'b0, b);
    check("tdo_idle_en", tdo_en_n, 1'b1);
    scan(1'b0, 32, '0, sout);
    check("idcode", sout[31:0], JDS_IDCODE);
    check("id_lsb", sout[0], 1'b1);
    foreach (codes[k]) begin
      scan(1'b1, 8, JDS_BSR_LEN'(codes[k]), sout);
      check("ir_capture", sout[7:0], {status, JDS_IR_CAPTURE_LOW});
      lfsr = next_rand(lfsr);
      scan(1'b0, 8, JDS_BSR_LEN'(lfsr), sout);
      check("bypass", sout[7:0], {lfsr[6:0], 1'b0});
    end
    // Boundary register captures the pins, then drives what was shifted in
    scan(1'b1, 8, JDS_BSR_LEN'(JDS_OP_EXTEST), sout);
    scan(1'b0, JDS_BSR_LEN, ~pin_in, sout);
    for (int k = 0; k < JDS_BSR_LEN; k += 32) begin
      check("bsr_capture", 32'(sout >> k), 32'(pin_in >> k));
      check("bsr_drive", 32'(pin_drive >> k), 32'(~pin_in >> k));
    end
    check("bsr_drive_en", drive_en, 1'b1);
    wb(1'b0, JDS_ADDR_CTRL, 32'h0, rd);
    check("ctrl_kept", rd, 32'h80);
    scan(1'b1, 8, JDS_BSR_LEN'(JDS_OP_IDCODE), sout);
    // Test port owns the chain: data returns through two more stages
    wb(1'b1, JDS_ADDR_CTRL, 32'h0, rd);
    repeat (8) @(posedge clock);
    check("src_test", src, JDS_SRC_TEST);
    wb(1'b0, JDS_ADDR_STATUS, 32'h0, rd);
    check("status_src", rd[5:4], JDS_SRC_TEST);
    scan(1'b0, 32, '0, sout);
    check("series", sout[31:2], JDS_IDCODE[29:0]);
    check("chain_return", chain_ret, tgt_ret);
    // Source table corners then random settings
    for (int i = 0; i < 30; i++) begin
      lfsr = next_rand(lfsr);
      ctrl = (i < 6) ? corners[i] : (lfsr & JDS_CTRL_MASK);
      mode_pin <= (i < 6) ? i[0] : lfsr[20];
      addr_pin <= lfsr[14:12];
      flash_c <= lfsr[24:22];
      host_c <= lfsr[28:26];
      wb(1'b1, JDS_ADDR_CTRL, ctrl, rd);
      repeat (6) @(posedge clock);
      wb(1'b0, JDS_ADDR_CTRL, 32'h0, rd);
      check("ctrl_rb", rd, ctrl & JDS_CTRL_MASK);
      es = src_of(ctrl, mode_pin);
      check("mode_eff", eff_mode,
            ctrl[JDS_CTL_MODE_OVR] ? ctrl[JDS_CTL_MODE] : mode_pin);
      check("image_addr", img,
            ctrl[JDS_CTL_ADDR_OVR] ? ctrl[JDS_CTL_ADDR_LSB +: 3] : addr_pin);
      check("source", src, es);
      if (es == JDS_SRC_FLASH) check("chain_flash", tgt, flash_c);
      if (es == JDS_SRC_HOST) check("chain_host", tgt, host_c);
      if (es == JDS_SRC_NONE) check("chain_none", tgt, JDS_CHAIN_IDLE);
    end
    conclude();
  end
endmodule
